// ==== strc_run_control.sv ====
`include "strc_defines.svh"
`default_nettype none

module strc_run_control
  import strc_pkg::*;
#(
  parameter int INDEX_W = `STRC_INDEX_W,
  parameter int LOW_W = `STRC_LOW_BITS_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Host settings
  input wire strc_run_e run_mode_in,
  input wire logic dynamic_switch_enable_in,
  input wire logic port_input_disable_in,
  input wire logic selection_port_width_in,
  input wire logic static_sel_we_in,
  input wire logic [INDEX_W-1:0] static_sel_in,
  input wire logic dynamic_entry_pick_we_in,
  input wire logic [INDEX_W-1:0] dynamic_entry_pick_in,
  input wire logic scenario_start_we_in,
  input wire logic [INDEX_W-1:0] scenario_start_index_in,
  input wire logic scenario_adv_we_in,
  input wire strc_adv_e scenario_advance_mode_in,
  input wire logic scenario_count_we_in,
  input wire logic [31:0] scenario_loop_count_in,
  input wire logic streaming_req_in,
  input wire logic streaming_val_in,
  // Sequencer events
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic trigger_in,
  input wire logic advance_in,
  input wire logic entry_done_in,
  input wire logic last_entry_in,
  // Dynamic selection port
  input wire logic port_strobe_in,
  input wire logic [INDEX_W-1:0] port_value_in,
  // Sample path
  input wire strc_out_e out_mode_in,
  input wire logic [31:0] sample_word_in,
  // Readback
  output logic [31:0] sequencer_status_word_out,
  output logic [INDEX_W-1:0] dynamic_entry_pick_out,
  output logic [INDEX_W-1:0] scenario_start_index_out,
  output strc_adv_e scenario_advance_mode_out,
  output logic [31:0] scenario_loop_count_out,
  output logic streaming_enable_out,
  output logic [INDEX_W-1:0] next_entry_out,
  output logic select_refused_out,
  // Converter side
  output logic [15:0] dac_code_out,
  output logic [14:0] iq_i_out,
  output logic [14:0] iq_q_out,
  output logic [7:0] capacity_msa_out
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  strc_exec_e state_reg;
  logic [INDEX_W-1:0] entry_reg;
  logic [INDEX_W-1:0] static_sel_reg;
  logic [31:0] loops_left_reg;
  logic running;
  logic [INDEX_W-1:0] port_index;
  logic port_take;

  assign running = (state_reg != STRC_IDLE);

  function automatic logic [INDEX_W-1:0] mask_port(input logic [INDEX_W-1:0] v,
                                                   input logic all_bits);
    logic [INDEX_W-1:0] m;
    m = '0;
    for (int i = 0; i < INDEX_W; i++) begin
      m[i] = all_bits || (i < LOW_W);
    end
    mask_port = v & m;
  endfunction : mask_port

  assign port_index = mask_port(port_value_in, selection_port_width_in);

  // Port counts only in dynamic mode with the hardware input enabled
  assign port_take = dynamic_switch_enable_in && !port_input_disable_in && port_strobe_in;

  // ----------------------------------------
  // Host settings
  // ----------------------------------------
  // Static choice refused while running, unless dynamic switching is enabled
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      static_sel_reg <= '0;
    end else if (static_sel_we_in && (!running || dynamic_switch_enable_in)) begin
      static_sel_reg <= static_sel_in;
    end
  end

  // Pulse lets the host see the write was dropped
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      select_refused_out <= 1'b0;
    end else begin
      select_refused_out <= static_sel_we_in && running && !dynamic_switch_enable_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      dynamic_entry_pick_out <= '0;
    end else if (dynamic_entry_pick_we_in) begin
      dynamic_entry_pick_out <= dynamic_entry_pick_in;
    end else if (port_take) begin
      // Port sampled once per strobe; value must be stable then
      dynamic_entry_pick_out <= port_index;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      scenario_start_index_out <= '0;
    end else if (scenario_start_we_in) begin
      scenario_start_index_out <= scenario_start_index_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      scenario_advance_mode_out <= STRC_ADV_AUTO;
    end else if (scenario_adv_we_in) begin
      scenario_advance_mode_out <= scenario_advance_mode_in;
    end
  end

  // All-ones word stands for -1, endless repeat
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      scenario_loop_count_out <= `STRC_LOOP_RESET;
    end else if (scenario_count_we_in) begin
      scenario_loop_count_out <= scenario_loop_count_in;
    end
  end

  // Leaving dynamic mode drops streaming too
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      streaming_enable_out <= 1'b0;
    end else if (!dynamic_switch_enable_in) begin
      streaming_enable_out <= 1'b0;
    end else if (streaming_req_in) begin
      streaming_enable_out <= streaming_val_in;
    end
  end

  // ----------------------------------------
  // Next entry choice
  // ----------------------------------------
  // Scenario start applies only outside dynamic mode
  always_comb begin
    if (dynamic_switch_enable_in) begin
      next_entry_out = dynamic_entry_pick_out;
    end else if (run_mode_in == STRC_RUN_SCEN) begin
      next_entry_out = scenario_start_index_out;
    end else begin
      next_entry_out = static_sel_reg;
    end
  end

  // ----------------------------------------
  // Execution state
  // ----------------------------------------
  logic arm_now;
  logic step_done;
  logic scen_wrap;
  logic scen_last;

  // Stop outranks every move, so each helper leaves it out
  assign arm_now = (state_reg == STRC_IDLE) && start_in && !stop_in;
  assign step_done = (state_reg == STRC_RUN) && entry_done_in && !stop_in;
  assign scen_wrap = step_done && last_entry_in && !dynamic_switch_enable_in
                     && (run_mode_in == STRC_RUN_SCEN);
  // Final pass ends in idle even under a waiting advance mode
  assign scen_last = scen_wrap && (loops_left_reg == 32'h00000001);

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_reg <= STRC_IDLE;
    end else if (stop_in) begin
      state_reg <= STRC_IDLE;
    end else begin
      case (state_reg)
        STRC_IDLE: begin
          if (start_in) begin
            state_reg <= STRC_WAIT_TRIG;
          end
        end
        STRC_WAIT_TRIG: begin
          if (trigger_in) begin
            state_reg <= STRC_RUN;
          end
        end
        STRC_RUN: begin
          if (scen_last) begin
            state_reg <= STRC_IDLE;
          end else if (step_done && (scenario_advance_mode_out != STRC_ADV_AUTO)) begin
            state_reg <= STRC_WAIT_ADV;
          end
        end
        STRC_WAIT_ADV: begin
          if (advance_in) begin
            state_reg <= STRC_RUN;
          end
        end
        default: begin
          state_reg <= STRC_IDLE;
        end
      endcase
    end
  end

  // Index kept through stop; host must not trust it in idle
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      entry_reg <= '0;
    end else if (arm_now) begin
      entry_reg <= next_entry_out;
    end else if (step_done && !scen_last) begin
      if (dynamic_switch_enable_in) begin
        entry_reg <= dynamic_entry_pick_out;
      end else if (scen_wrap) begin
        entry_reg <= scenario_start_index_out;
      end else begin
        entry_reg <= entry_reg + {{(INDEX_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // All-ones never counts down, so -1 repeats until stopped
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      loops_left_reg <= 32'h00000000;
    end else if (arm_now) begin
      loops_left_reg <= scenario_loop_count_out;
    end else if (scen_wrap && !scen_last && (loops_left_reg != 32'hFFFFFFFF)) begin
      loops_left_reg <= loops_left_reg - 32'h00000001;
    end
  end

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  function automatic logic [31:0] pack_status(input strc_exec_e s,
                                              input logic [INDEX_W-1:0] e);
    pack_status = {{`STRC_ST_RSVD_W{1'b0}}, s, e};
  endfunction : pack_status

  // One register so a read never mixes two cycles
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      sequencer_status_word_out <= 32'h00000000;
    end else begin
      sequencer_status_word_out <= pack_status(state_reg,
                                               entry_reg);
    end
  end

  // ----------------------------------------
  // Sample path
  // ----------------------------------------
  strc_sample_path u_path (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .out_mode_in(out_mode_in),
    .sample_word_in(sample_word_in),
    .dac_code_out(dac_code_out),
    .iq_i_out(iq_i_out),
    .iq_q_out(iq_q_out),
    .capacity_msa_out(capacity_msa_out)
  );

endmodule : strc_run_control

`default_nettype wire

// ==== strc_defines.svh ====
`ifndef STRC_DEFINES_SVH
`define STRC_DEFINES_SVH

// ----------------------------------------
// Status word layout
// ----------------------------------------
`define STRC_ST_STATE_HI 20
`define STRC_ST_STATE_LO 19
`define STRC_ST_INDEX_HI 18
`define STRC_ST_INDEX_LO 0
`define STRC_ST_RSVD_W 11
`define STRC_INDEX_W 19

// ----------------------------------------
// Sample widths and memory capacity
// ----------------------------------------
`define STRC_SPEED_BITS 12
`define STRC_PREC_BITS 14
`define STRC_IQ_BITS 15
`define STRC_DIRECT_CAP_MSA 128
`define STRC_INTERP_CAP_MSA 64

// ----------------------------------------
// Reset values and selection port low width
// ----------------------------------------
`define STRC_LOOP_RESET 32'h00000001
`define STRC_LOW_BITS_W 13

`endif

// ==== strc_pkg.sv ====
`default_nettype none

package strc_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    STRC_IDLE,
    STRC_WAIT_TRIG,
    STRC_RUN,
    STRC_WAIT_ADV
  } strc_exec_e;

  typedef enum logic [1:0] {
    STRC_ADV_AUTO,
    STRC_ADV_ADVANCE_CONDITIONAL,
    STRC_ADV_REP,
    STRC_ADV_ADVANCE_SINGLE
  } strc_adv_e;

  typedef enum logic [2:0] {
    STRC_OUT_SPEED,
    STRC_OUT_PREC,
    STRC_OUT_X3,
    STRC_OUT_X12,
    STRC_OUT_X24,
    STRC_OUT_X48
  } strc_out_e;

  typedef enum logic [1:0] {
    STRC_RUN_ARB,
    STRC_RUN_SEQ,
    STRC_RUN_SCEN
  } strc_run_e;

endpackage : strc_pkg

`default_nettype wire

// ==== strc_sample_path.sv ====
`include "strc_defines.svh"
`default_nettype none

module strc_sample_path
  import strc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Mode and data
  input wire strc_out_e out_mode_in,
  input wire logic [31:0] sample_word_in,
  // Converter side
  output logic [15:0] dac_code_out,
  output logic [14:0] iq_i_out,
  output logic [14:0] iq_q_out,
  output logic [7:0] capacity_msa_out
);

  // ----------------------------------------
  // Direct and interpolated paths
  // ----------------------------------------
  function automatic logic is_interp(input strc_out_e m);
    is_interp = (m != STRC_OUT_SPEED) && (m != STRC_OUT_PREC);
  endfunction : is_interp

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      dac_code_out <= 16'h0000;
    end else if (out_mode_in == STRC_OUT_SPEED) begin
      // Low four bits are markers and don't-care
      dac_code_out <= {sample_word_in[15:4], 4'h0};
    end else if (out_mode_in == STRC_OUT_PREC) begin
      dac_code_out <= {sample_word_in[15:2], 2'h0};
    end else begin
      dac_code_out <= dac_code_out;
    end
  end

  // Modulator itself sits downstream; only the pair is latched here
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      iq_i_out <= 15'h0000;
      iq_q_out <= 15'h0000;
    end else if (is_interp(out_mode_in)) begin
      iq_i_out <= sample_word_in[14:0];
      iq_q_out <= sample_word_in[30:16];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      capacity_msa_out <= 8'(`STRC_DIRECT_CAP_MSA);
    end else begin
      capacity_msa_out <= is_interp(out_mode_in) ? 8'(`STRC_INTERP_CAP_MSA)
                                                 : 8'(`STRC_DIRECT_CAP_MSA);
    end
  end

endmodule : strc_sample_path

`default_nettype wire

// ==== strc_run_control_checker.sv ====
`default_nettype none
module strc_run_control_checker
  import strc_pkg::*;
#(parameter int INDEX_W = 19) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic trigger_in,
  input wire logic static_sel_we_in,
  input wire logic dynamic_switch_enable_in,
  input wire logic dynamic_entry_pick_we_in,
  input wire logic [INDEX_W-1:0] dynamic_entry_pick_in,
  input wire logic scenario_count_we_in,
  input wire logic [31:0] scenario_loop_count_in,
  input wire strc_out_e out_mode_in,
  input wire logic [31:0] sample_word_in,
  input wire logic [31:0] sequencer_status_word_out,
  input wire logic [INDEX_W-1:0] dynamic_entry_pick_out,
  input wire logic [31:0] scenario_loop_count_out,
  input wire logic streaming_enable_out,
  input wire logic select_refused_out,
  input wire logic [14:0] iq_i_out,
  input wire logic [7:0] capacity_msa_out
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [1:0] st = sequencer_status_word_out[20:19];
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // ----------------------------------------
  // Run walk
  // ----------------------------------------
  sequence s_arm;
    (start_in && !stop_in && !$past(start_in) && st == 2'h0) ##1 !stop_in;
  endsequence
  sequence s_fire;
    (trigger_in && !stop_in && !$past(trigger_in) && !$past(start_in)
      && !$past(stop_in) && st == 2'h1) ##1 !stop_in;
  endsequence
  a_arm_waits: assert property (s_arm |=> st == 2'h1)
    else $error("start did not reach trigger wait");
  a_trig_runs: assert property (s_fire |=> st == 2'h2)
    else $error("trigger did not reach running");
  a_stop_idle: assert property (stop_in |=> ##1 st == 2'h0)
    else $error("stop did not reach idle");
  a_rsvd_zero: assert property (sequencer_status_word_out[31:21] == 11'h0)
    else $error("reserved status bits set");
  // ----------------------------------------
  // Settings
  // ----------------------------------------
  a_refuse_cause: assert property (select_refused_out |->
    $past(static_sel_we_in) && !$past(dynamic_switch_enable_in))
    else $error("refusal without static write");
  a_pick_back: assert property (dynamic_entry_pick_we_in |=>
    dynamic_entry_pick_out == $past(dynamic_entry_pick_in))
    else $error("pick readback wrong");
  a_count_back: assert property (scenario_count_we_in |=>
    scenario_loop_count_out == $past(scenario_loop_count_in))
    else $error("loop count readback wrong");
  a_stream_gate: assert property (streaming_enable_out |-> $past(dynamic_switch_enable_in))
    else $error("streaming without dynamic mode");
  a_iq_path: assert property (out_mode_in >= STRC_OUT_X3 |=>
    iq_i_out == $past(sample_word_in[14:0]))
    else $error("I sample not passed");
  a_cap_mode: assert property ($stable(out_mode_in) |=> capacity_msa_out ==
    ($past(out_mode_in) <= STRC_OUT_PREC ? 8'h80 : 8'h40))
    else $error("capacity wrong for mode");
endmodule : strc_run_control_checker
`default_nettype wire

// ==== strc_port_model.sv ====
`default_nettype none
module strc_port_model (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [18:0] value_in,
  output logic strobe_out,
  output logic [18:0] value_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Value valid only with strobe; stale data inverted each cycle so it never looks stable
  always_ff @(posedge clk_in) begin
    strobe_out <= go_in;
    value_out <= go_in ? value_in : ~value_out;
  end
endmodule : strc_port_model
`default_nettype wire

// ==== strc_run_control_test.sv ====
`default_nettype none
module strc_run_control_test
  import strc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, nrst_in = 0, dyn = 0, pdis = 0, pw = 1, swe = 0, pwe = 0, cwe = 0;
  logic awe = 0, nwe = 0, sreq = 0, sval = 0, start = 0, stop = 0, trig = 0, go = 0, pstb;
  logic [18:0] ssel = 0, pick = 0, sidx = 0, gv = 0, pval, pick_o, sidx_o, nxt;
  logic [31:0] cnt = 0, word = 0, stat, cnt_o;
  strc_run_e rmode = STRC_RUN_SEQ;
  strc_adv_e adv = STRC_ADV_AUTO, adv_o;
  strc_out_e omode = STRC_OUT_SPEED;
  logic sen, refd;
  logic [7:0] cap;
  logic [14:0] iqi, iqq;
  logic [15:0] dac;
  logic done = 0, last = 0, aev = 0;
  int n_fail = 0, cmp_count = 0;
  initial forever #5 clk_in = ~clk_in;
  strc_port_model port_m (.clk_in(clk_in), .go_in(go), .value_in(gv), .strobe_out(pstb),
    .value_out(pval));
  strc_run_control DUT (.clk_in(clk_in), .nrst_in(nrst_in), .run_mode_in(rmode),
    .dynamic_switch_enable_in(dyn), .port_input_disable_in(pdis),
    .selection_port_width_in(pw), .static_sel_we_in(swe), .static_sel_in(ssel),
    .dynamic_entry_pick_we_in(pwe), .dynamic_entry_pick_in(pick),
    .scenario_start_we_in(nwe), .scenario_start_index_in(sidx), .scenario_adv_we_in(awe),
    .scenario_advance_mode_in(adv), .scenario_count_we_in(cwe),
    .scenario_loop_count_in(cnt), .streaming_req_in(sreq), .streaming_val_in(sval),
    .start_in(start), .stop_in(stop), .trigger_in(trig), .advance_in(aev),
    .entry_done_in(done), .last_entry_in(last), .port_strobe_in(pstb),
    .port_value_in(pval), .out_mode_in(omode), .sample_word_in(word),
    .sequencer_status_word_out(stat), .dynamic_entry_pick_out(pick_o),
    .scenario_start_index_out(sidx_o), .scenario_advance_mode_out(adv_o),
    .scenario_loop_count_out(cnt_o), .streaming_enable_out(sen), .next_entry_out(nxt),
    .select_refused_out(refd), .dac_code_out(dac), .iq_i_out(iqi), .iq_q_out(iqq),
    .capacity_msa_out(cap));
  task automatic tk(input int n = 1);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tk
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic t_walk;
    sidx = 19'h5A3C1; nwe = 1; rmode = STRC_RUN_SCEN; tk; nwe = 0;
    chk(sidx_o, 19'h5A3C1);
    start = 1; tk; start = 0; tk;
    chk(stat, {11'h0, 2'h1, 19'h5A3C1});
    trig = 1; tk; trig = 0; tk;
    chk(stat[20:19], 2'h2);
    swe = 1; ssel = 19'h00042; rmode = STRC_RUN_SEQ; tk; swe = 0;
    chk(refd, 1'b1);
    stop = 1; tk; stop = 0; tk;
    chk(stat[20:19], 2'h0);
    swe = 1; tk; swe = 0;
    chk(refd, 1'b0);
    chk(nxt, 19'h00042);
  endtask : t_walk
  task automatic t_dyn;
    dyn = 1; pick = 19'h3FFFF; pwe = 1; tk; pwe = 0;
    chk(pick_o, 19'h3FFFF);
    chk(nxt, 19'h3FFFF);
    for (int i = 0; i < 3; i++) begin
      pw = (i == 0); pdis = (i == 2); gv = 19'h7E5A5 ^ 19'(i); go = 1; tk; go = 0; tk;
      chk(nxt, i == 0 ? 19'h7E5A5 : 19'h005A4);
    end
    sreq = 1; sval = 1; tk; sreq = 0;
    chk(sen, 1'b1);
    dyn = 0; tk(2);
    chk(sen, 1'b0);
    sreq = 1; tk; sreq = 0;
    chk(sen, 1'b0);
  endtask : t_dyn
  task automatic t_regs;
    awe = 1;
    for (int a = 0; a < 4; a++) begin
      adv = strc_adv_e'(a);
      tk;
      chk(adv_o, a[1:0]);
    end
    awe = 0;
    cnt = 32'hFFFFFFFF;
    cwe = 1;
    tk;
    chk(cnt_o, 32'hFFFFFFFF);
    cnt = 32'hFFFFFFFE;
    tk;
    cwe = 0;
    chk(cnt_o, 32'hFFFFFFFE);
    for (int m = 0; m < 6; m++) begin
      omode = strc_out_e'(m); word = 32'h1234ABCD + m; tk(2);
      chk(cap, m < 2 ? 8'h80 : 8'h40);
      if (m < 2) chk(dac, m == 0 ? 16'hABC0 : 16'hABCC);
      if (m > 1) chk(iqi, word[14:0]);
      if (m > 1) chk(iqq, 15'h1234);
    end
  endtask : t_regs
  task automatic t_scen;
    rmode = STRC_RUN_SCEN;
    cnt = 32'h00000002;
    cwe = 1;
    adv = STRC_ADV_ADVANCE_CONDITIONAL;
    awe = 1;
    tk;
    cwe = 0;
    awe = 0;
    start = 1;
    tk;
    start = 0;
    trig = 1;
    tk;
    trig = 0;
    done = 1;
    tk;
    done = 0;
    tk;
    chk(stat, {11'h0, 2'h3, 19'h5A3C2});
    for (int p = 0; p < 2; p++) begin
      aev = 1;
      tk;
      aev = 0;
      done = 1;
      last = 1;
      tk;
      done = 0;
      last = 0;
      tk;
      chk(stat[20:19], p == 0 ? 2'h3 : 2'h0);
      if (p == 0) chk(stat[18:0], 19'h5A3C1);
    end
  endtask : t_scen
  task automatic print_verdict;
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  initial begin
    tk(20);
    nrst_in = 1;
    chk(stat, 32'h0);
    chk(cnt_o, 32'h1);
    chk(cap, 8'h80);
    t_walk;
    t_dyn;
    t_regs;
    t_scen;
    print_verdict;
  end
  initial begin
    #20000;
    n_fail++;
    print_verdict;
  end
endmodule : strc_run_control_test
bind strc_run_control strc_run_control_checker #(.INDEX_W(INDEX_W)) chk_i (
  .clk_in(clk_in), .nrst_in(nrst_in), .start_in(start_in), .stop_in(stop_in),
  .trigger_in(trigger_in), .static_sel_we_in(static_sel_we_in),
  .dynamic_switch_enable_in(dynamic_switch_enable_in),
  .dynamic_entry_pick_we_in(dynamic_entry_pick_we_in),
  .dynamic_entry_pick_in(dynamic_entry_pick_in), .scenario_count_we_in(scenario_count_we_in),
  .scenario_loop_count_in(scenario_loop_count_in), .out_mode_in(out_mode_in),
  .sample_word_in(sample_word_in), .sequencer_status_word_out(sequencer_status_word_out),
  .dynamic_entry_pick_out(dynamic_entry_pick_out),
  .scenario_loop_count_out(scenario_loop_count_out),
  .streaming_enable_out(streaming_enable_out), .select_refused_out(select_refused_out),
  .iq_i_out(iq_i_out), .capacity_msa_out(capacity_msa_out));
`default_nettype wire
